// ---- pmcg_ctrl.sv ----
// Strobed register access was chosen for this implementation.
`timescale 1ns/1ps
module pmcg_ctrl
  import pmcg_pkg::*;
#(
  parameter int NUM_INT = 9
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire pmcg_bus_t bus,
  output logic [7:0] rdata,
  input wire logic [NUM_INT-1:0] int_enable,
  input wire logic [NUM_INT-1:0] int_blocked,
  input wire logic [NUM_INT-1:0] int_pin_n,
  input wire logic [NUM_INT-1:0] int_is_pin,
  input wire logic unclocked_wake,
  input wire logic uart_rx_pin,
  input wire logic uart_rx_enable,
  input wire logic uart_tx_load,
  input wire logic reset_pin_n,
  input wire logic wdt_reset,
  input wire logic slow_osc_tick,
  input wire logic src_stable,
  output pmcg_ctl_t ctl,
  output logic cpu_tick
);
  // ****************************************
  // Parameter check
  // ****************************************
  if (NUM_INT != 9) begin : g_bad_num
    $error("pmcg_ctrl supports exactly nine interrupt lines");
  end

  typedef struct packed {
    pmcg_mode_t mode;
    logic [7:0] divctl;
    logic [7:0] clock_source_field;
    logic [7:0] wake_up_mask;
    logic idle_bit;
    logic stop_bit;
    logic sleep_bit;
    logic [8:0] div_cnt;
    logic [7:0] settle_cnt;
    logic [2:0] rx_sync;
    logic [1:0] rst_sync;
    logic [NUM_INT-1:0] pin_s1;
    logic [NUM_INT-1:0] pin_s2;
    logic [7:0] rdata;
    pmcg_ctl_t ctl;
    logic cpu_tick;
    logic sel_slow;
  } pmcg_state_t;

  pmcg_state_t st_r;
  pmcg_state_t st_nxt;
  logic [NUM_INT-1:0] trig;
  logic [NUM_INT-1:0] mask_map;
  logic in_div;
  logic sb_event;
  logic wake_any;
  logic stop_wake;
  logic [8:0] settle_len;

  // ****************************************
  // Wake-source qualification
  // ****************************************
  // Interrupt 5 has no wake mask bit, so it never wakes from stop
  assign mask_map = {st_r.wake_up_mask[7:5], 1'b0, st_r.wake_up_mask[4:0]};
  genvar gi;
  generate
    for (gi = 0; gi < NUM_INT; gi++) begin : g_trig
      // Pins low-active, peripheral flags high-active
      assign trig[gi] = int_enable[gi] &
                        (int_is_pin[gi] ? ~st_r.pin_s2[gi] : st_r.pin_s2[gi]);
    end
  endgenerate
  assign in_div = (st_r.divctl[PMCG_DIV_FLD_POS +: 2] == PMCG_DIV_ON);
  // Interrupt 5 is not a switch-back source
  assign sb_event = st_r.divctl[PMCG_DIV_SWB_POS] & in_div &
                    ((|(trig & ~int_blocked & 9'h1DF)) |
                     (st_r.rx_sync[2] & ~st_r.rx_sync[1] & uart_rx_enable) |
                     uart_tx_load);
  assign wake_any = |(trig & ~int_blocked);
  assign stop_wake = (|(trig & mask_map)) | unclocked_wake;
  assign settle_len = 9'(PMCG_SETTLE_BASE) << st_r.clock_source_field[PMCG_CKS_SETTLE_POS +: 2];

  // ****************************************
  // Next-state logic
  // ****************************************
  always_comb begin
    st_nxt = st_r;
    st_nxt.pin_s1 = int_pin_n;
    st_nxt.pin_s2 = st_r.pin_s1;
    st_nxt.rx_sync = {st_r.rx_sync[1:0], uart_rx_pin};
    st_nxt.rst_sync = {st_r.rst_sync[0], reset_pin_n};
    st_nxt.rdata = 8'h00;
    st_nxt.ctl.wake_pulse = 1'b0;
    // Register reads, one cycle latency
    if (bus.rd) begin
      unique case (bus.addr)
        PMCG_POWER_CONTROL_REGISTER_OFS: st_nxt.rdata = 8'({st_r.sleep_bit, 2'b00, st_r.stop_bit,
                                          st_r.idle_bit});
        PMCG_DIVCTL_OFS: st_nxt.rdata = {st_r.divctl[7:5], 5'h00};
        PMCG_CLOCK_SOURCE_FIELD_OFS: st_nxt.rdata = {6'h00, st_r.clock_source_field[1:0]};
        PMCG_WAKE_UP_MASK_OFS: st_nxt.rdata = st_r.wake_up_mask;
        default: st_nxt.rdata = 8'h00;
      endcase
    end
    // Register writes
    if (bus.wr) begin
      unique case (bus.addr)
        PMCG_POWER_CONTROL_REGISTER_OFS: begin
          st_nxt.idle_bit = bus.wdata[PMCG_POWER_CONTROL_REGISTER_IDLE_POS];
          st_nxt.stop_bit = bus.wdata[PMCG_POWER_CONTROL_REGISTER_STOP_POS];
          st_nxt.sleep_bit = bus.wdata[PMCG_POWER_CONTROL_REGISTER_SLEEP_POS];
        end
        PMCG_DIVCTL_OFS: st_nxt.divctl = {bus.wdata[7:5], 5'h00};
        PMCG_CLOCK_SOURCE_FIELD_OFS: st_nxt.clock_source_field = {4'h0, bus.wdata[3:0]};
        PMCG_WAKE_UP_MASK_OFS: st_nxt.wake_up_mask = bus.wdata;
        default: st_nxt = st_nxt;
      endcase
    end
    // Switch-back only ever leaves divided mode
    if (sb_event) begin
      st_nxt.divctl[PMCG_DIV_FLD_POS +: 2] = PMCG_DIV_FULL;
    end
    // Pin reset is sampled through two stages; watchdog reset is on-clock
    if (wdt_reset | ~st_r.rst_sync[1]) begin
      st_nxt.divctl = PMCG_DIVCTL_RST;
    end
    // Clock source follows the field only when the new source is stable; stop wake forces the internal oscillator
    if (src_stable) begin
      st_nxt.sel_slow = st_r.clock_source_field[PMCG_CKS_SEL_POS + 1];
    end
    // Divided CPU tick; external clock stays ungated
    st_nxt.div_cnt = (in_div && st_r.div_cnt != PMCG_DIV_LAST) ? st_r.div_cnt + 9'h001 : 9'h000;
    st_nxt.cpu_tick = (st_r.mode == PMCG_RUN) && (!in_div || st_r.div_cnt == PMCG_DIV_LAST);
    unique case (st_r.mode)
      PMCG_RUN: begin
        if (st_r.stop_bit) begin
          st_nxt.mode = PMCG_STOP;
        end else if (st_r.idle_bit) begin
          st_nxt.mode = PMCG_IDLE;
        end
      end
      PMCG_IDLE: begin
        if (wake_any || !st_r.rst_sync[1]) begin
          st_nxt.idle_bit = 1'b0;
          st_nxt.ctl.wake_pulse = wake_any;
          st_nxt.mode = PMCG_RUN;
        end
      end
      PMCG_STOP: begin
        if (stop_wake || !st_r.rst_sync[1]) begin
          st_nxt.stop_bit = 1'b0;
          st_nxt.sel_slow = 1'b0;
          st_nxt.clock_source_field[1:0] = 2'h0;
          st_nxt.settle_cnt = 8'h00;
          st_nxt.mode = st_r.sleep_bit ? PMCG_SETTLE : PMCG_RESUME;
        end
      end
      PMCG_SETTLE: begin
        if (slow_osc_tick) begin
          st_nxt.settle_cnt = st_r.settle_cnt + 8'h01;
        end
        if ({1'b0, st_r.settle_cnt} >= settle_len - 9'h001) begin
          st_nxt.sleep_bit = 1'b0;
          st_nxt.mode = PMCG_RESUME;
        end
      end
      PMCG_RESUME: begin
        st_nxt.ctl.wake_pulse = 1'b1;
        st_nxt.mode = PMCG_RUN;
      end
      default: st_nxt.mode = PMCG_RUN;
    endcase
    // Output decode from next mode, registered
    st_nxt.ctl.cpu_clk_en = (st_nxt.mode == PMCG_RUN) || (st_nxt.mode == PMCG_RESUME);
    st_nxt.ctl.ext_clk_en = (st_nxt.mode == PMCG_RUN) || (st_nxt.mode == PMCG_IDLE) ||
                            (st_nxt.mode == PMCG_RESUME);
    st_nxt.ctl.internal_oscillator_en = (st_nxt.mode != PMCG_STOP);
    st_nxt.ctl.main_reg_en = !(st_nxt.mode == PMCG_STOP && st_r.sleep_bit);
    st_nxt.ctl.sel_slow = st_nxt.sel_slow;
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      st_r <= '{mode: PMCG_RUN, divctl: PMCG_DIVCTL_RST, clock_source_field: PMCG_CLOCK_SOURCE_FIELD_RST,
                wake_up_mask: PMCG_WAKE_UP_MASK_RST, rst_sync: 2'b11, pin_s1: '1, pin_s2: '1,
                ctl: '{cpu_clk_en: 1'b1, ext_clk_en: 1'b1, internal_oscillator_en: 1'b1,
                       main_reg_en: 1'b1, sel_slow: 1'b0, wake_pulse: 1'b0},
                default: '0};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign rdata = st_r.rdata;
  assign ctl = st_r.ctl;
  assign cpu_tick = st_r.cpu_tick;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  // A tick taken just as division ends may be followed by full-speed ticks
  a_div_tick_gap: assert property ((in_div && st_r.mode == PMCG_RUN && cpu_tick) |->
    ##1 ((!cpu_tick || !in_div) [*8])) else $error("divided tick too frequent");
  a_ext_in_div: assert property (in_div && st_r.mode == PMCG_RUN |-> ctl.ext_clk_en)
    else $error("external clock gated in divided mode");
  a_full_write: assert property (bus.wr && bus.addr == PMCG_DIVCTL_OFS &&
    bus.wdata[7:6] == PMCG_DIV_FULL |=> !in_div) else $error("full speed not restored");
  a_switch_back: assert property (sb_event && !bus.wr |=> !in_div)
    else $error("switch-back ignored");
  a_no_reentry: assert property (!in_div && !(bus.wr && bus.addr == PMCG_DIVCTL_OFS) |=>
    !in_div) else $error("divided mode re-entered by hardware");
  a_wdt_exit: assert property (wdt_reset |=> !in_div) else $error("watchdog kept divider");
  // Reset pin also ends idle, without a vector
  a_idle_gate: assert property (st_r.mode == PMCG_IDLE |=> !ctl.cpu_clk_en || $past(wake_any) ||
    !$past(st_r.rst_sync[1])) else $error("cpu clock runs in idle");
  a_stop_osc: assert property (st_r.mode == PMCG_STOP && !stop_wake && st_r.rst_sync[1] |=>
    !ctl.internal_oscillator_en && !ctl.ext_clk_en) else $error("clock alive in stop");
  a_stop_wake: assert property (st_r.mode == PMCG_STOP && stop_wake && !st_r.sleep_bit |=>
    !st_r.stop_bit ##1 ctl.wake_pulse) else $error("stop wake late");
  a_sleep_reg: assert property (st_r.mode == PMCG_STOP && st_r.sleep_bit |-> ##1
    (!ctl.main_reg_en || st_r.mode != PMCG_STOP)) else $error("regulator on in sleep");
  c_div_run: cover property (in_div ##1 sb_event ##1 !in_div);
  c_idle_wake: cover property (st_r.mode == PMCG_IDLE ##1 st_r.mode == PMCG_RUN);
  c_sleep_wake: cover property (st_r.mode == PMCG_SETTLE ##1 st_r.mode == PMCG_RESUME);
  c_stop_wake: cover property (st_r.mode == PMCG_STOP ##1 st_r.mode == PMCG_RESUME);
  c_idle_entry: cover property (st_r.mode == PMCG_RUN ##1 st_r.mode == PMCG_IDLE);

  // ****************************************
  // Mode outputs against mode state
  // ****************************************
  // Idle halts the CPU domain but keeps the external domain alive for wake sources
  a_idle_clk_off: assert property (st_r.mode == PMCG_IDLE |-> !ctl.cpu_clk_en && ctl.ext_clk_en)
    else $error("idle clock gating wrong");

  // Stop gates both clock domains
  a_stop_all_clk: assert property (st_r.mode == PMCG_STOP |-> !ctl.cpu_clk_en && !ctl.ext_clk_en)
    else $error("clock enabled in stop");

  // Oscillator is off for the whole stop interval
  a_osc_in_stop: assert property (st_r.mode == PMCG_STOP |-> !ctl.internal_oscillator_en)
    else $error("oscillator on in stop");

  // Oscillator runs in every other mode
  a_osc_outside_stop: assert property (st_r.mode != PMCG_STOP |-> ctl.internal_oscillator_en)
    else $error("oscillator off outside stop");

  // Main regulator is only ever off while halted in stop
  a_reg_outside_stop: assert property (st_r.mode != PMCG_STOP |-> ctl.main_reg_en)
    else $error("regulator off outside stop");

  // While the regulator settles the CPU stays halted on a running oscillator
  a_settle_hold: assert property (st_r.mode == PMCG_SETTLE |->
    !ctl.cpu_clk_en && ctl.internal_oscillator_en && ctl.main_reg_en)
    else $error("settle outputs wrong");

  // Settle counter only moves on a slow-oscillator tick
  a_settle_wait: assert property (st_r.mode == PMCG_SETTLE && !slow_osc_tick |=>
    $stable(st_r.settle_cnt))
    else $error("settle count moved without tick");

  // ****************************************
  // Mode transitions
  // ****************************************
  // Stop bit takes the block into stop on the next edge
  a_stop_entry: assert property (st_r.mode == PMCG_RUN && st_r.stop_bit |=>
    st_r.mode == PMCG_STOP)
    else $error("stop not entered");

  // Idle bit alone takes the block into idle
  a_idle_entry: assert property (st_r.mode == PMCG_RUN && st_r.idle_bit && !st_r.stop_bit |=>
    st_r.mode == PMCG_IDLE)
    else $error("idle not entered");

  // Idle is left only by an enabled interrupt or the reset pin
  a_idle_hold: assert property (st_r.mode == PMCG_IDLE && !wake_any && st_r.rst_sync[1] |=>
    st_r.mode == PMCG_IDLE)
    else $error("idle left without cause");

  // Interrupt wake from idle vectors and clears the idle bit
  a_idle_wake: assert property (st_r.mode == PMCG_IDLE && wake_any |=>
    st_r.mode == PMCG_RUN && !st_r.idle_bit && ctl.wake_pulse)
    else $error("idle wake incomplete");

  // Clocked sources cannot end stop; only qualified wakes or the pin
  a_stop_only_wake: assert property (st_r.mode == PMCG_STOP && !stop_wake && st_r.rst_sync[1] |=>
    st_r.mode == PMCG_STOP)
    else $error("stop left without wake");

  // Stop wake drops the stop bit and falls back to the internal oscillator
  a_stop_clr_sel: assert property (st_r.mode == PMCG_STOP && stop_wake |=>
    !st_r.stop_bit && !ctl.sel_slow)
    else $error("stop wake kept slow source");

  // Sleep wake must wait for the regulator before resuming
  a_sleep_settle: assert property (st_r.mode == PMCG_STOP && stop_wake && st_r.sleep_bit |=>
    st_r.mode == PMCG_SETTLE)
    else $error("sleep wake skipped settle");

  // Wake vector lasts exactly one cycle
  a_pulse_one: assert property (ctl.wake_pulse |=> !ctl.wake_pulse)
    else $error("wake pulse too long");

  // ****************************************
  // Divider and CPU tick
  // ****************************************
  // Full speed means a tick on every cycle that follows a running cycle
  a_tick_full: assert property (st_r.mode == PMCG_RUN && !in_div |=> cpu_tick)
    else $error("full speed tick missing");

  // No CPU tick in the cycle after a halted cycle
  a_no_tick_halt: assert property (st_r.mode != PMCG_RUN |=> !cpu_tick)
    else $error("tick while halted");

  // Divider counter never passes its wrap value
  a_div_cnt_range: assert property (st_r.div_cnt <= PMCG_DIV_LAST)
    else $error("divider count out of range");

  // Without switch-back enabled only software or a reset can end division
  a_sb_needs_swb: assert property (in_div && !st_r.divctl[PMCG_DIV_SWB_POS] && !wdt_reset &&
    st_r.rst_sync[1] && !(bus.wr && bus.addr == PMCG_DIVCTL_OFS) |=> in_div)
    else $error("division left without switch-back");

  // Synchronised reset pin clears division
  a_rst_pin_divoff: assert property (!st_r.rst_sync[1] |=> !in_div)
    else $error("reset pin kept divider");

  // ****************************************
  // Register port and clock source
  // ****************************************
  // Read data is zero outside the cycle after a read strobe
  a_rd_idle_zero: assert property (!bus.rd |=> rdata == 8'h00)
    else $error("read data without strobe");

  // Wake mask reads back as held
  a_wake_up_mask_rd: assert property (bus.rd && bus.addr == PMCG_WAKE_UP_MASK_OFS |=>
    rdata == $past(st_r.wake_up_mask))
    else $error("wake mask read wrong");

  // Source select follows the field once the new source is stable
  a_sel_follow: assert property (src_stable && st_r.mode == PMCG_RUN |=>
    ctl.sel_slow == $past(st_r.clock_source_field[1]))
    else $error("source select not applied");

  // In run, an unstable source never gets switched in
  a_sel_hold: assert property (!src_stable && st_r.mode == PMCG_RUN |=>
    $stable(ctl.sel_slow))
    else $error("source switched while unstable");
endmodule // pmcg_ctrl

// ---- pmcg_pkg.sv ----
package pmcg_pkg;
  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [7:0] PMCG_CLOCK_SOURCE_FIELD_OFS = 8'h8F;
  localparam logic [7:0] PMCG_POWER_CONTROL_REGISTER_OFS = 8'h87;
  localparam logic [7:0] PMCG_DIVCTL_OFS = 8'hC4;
  localparam logic [7:0] PMCG_WAKE_UP_MASK_OFS = 8'h9F;
  // ****************************************
  // Field positions and reset values
  // ****************************************
  localparam int PMCG_POWER_CONTROL_REGISTER_IDLE_POS = 0;
  localparam int PMCG_POWER_CONTROL_REGISTER_STOP_POS = 1;
  localparam int PMCG_POWER_CONTROL_REGISTER_SLEEP_POS = 4;
  localparam int PMCG_DIV_SWB_POS = 5;
  localparam int PMCG_DIV_FLD_POS = 6;
  localparam int PMCG_CKS_SEL_POS = 0;
  localparam int PMCG_CKS_SETTLE_POS = 2;
  localparam logic [1:0] PMCG_DIV_ON = 2'h3;
  localparam logic [1:0] PMCG_DIV_FULL = 2'h1;
  localparam logic [7:0] PMCG_DIVCTL_RST = 8'h40;
  localparam logic [7:0] PMCG_CLOCK_SOURCE_FIELD_RST = 8'h0C;
  localparam logic [7:0] PMCG_WAKE_UP_MASK_RST = 8'hFF;
  // ****************************************
  // Timing counts
  // ****************************************
  localparam int PMCG_DIV_RATIO = 257;
  localparam int PMCG_SETTLE_BASE = 16;
  localparam logic [8:0] PMCG_DIV_LAST = 9'(PMCG_DIV_RATIO - 1);
  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [2:0] {
    PMCG_RUN = 3'b000,
    PMCG_IDLE = 3'b001,
    PMCG_STOP = 3'b010,
    PMCG_SETTLE = 3'b011,
    PMCG_RESUME = 3'b100
  } pmcg_mode_t;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } pmcg_bus_t;
  typedef struct packed {
    logic cpu_clk_en;
    logic ext_clk_en;
    logic internal_oscillator_en;
    logic main_reg_en;
    logic sel_slow;
    logic wake_pulse;
  } pmcg_ctl_t;
endpackage

// ---- pmcg_irq_model.sv ----
`timescale 1ns/1ps
module pmcg_irq_model (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [8:0] req,
  input wire logic clr,
  input wire logic wake_pulse,
  output logic [8:0] int_pin_n,
  output logic [8:0] int_is_pin
);
  // ****************************************
  // Interrupt sources at the far side
  // ****************************************
  logic [8:0] act_r;
  assign int_is_pin = 9'h00F; // Low four are pins, the rest peripheral flags
  // Pins sit high when quiet, flags sit low
  assign int_pin_n = act_r ^ int_is_pin;
  // The vector clears the source, as a service routine would
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      act_r <= 9'h000;
    end else begin
      act_r <= (act_r | req) & ~{9{wake_pulse | clr}};
    end
  end
endmodule // pmcg_irq_model

// ---- tb.sv ----
`timescale 1ns/1ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin bad_count++; \
  $display("Error t=%0t got %h exp %h", $time, a, b); end end
module tb;
  import pmcg_pkg::*;
  // ****************************************
  // Stimulus and design
  // ****************************************
  logic clk_sys, rst, tx_ld, rx_pin, wdt_rst, clr, rd_q, rx_en, slow_tick;
  logic [8:0] req, pin_n, is_pin;
  logic [7:0] rdata, exp_v;
  logic [31:0] seed;
  pmcg_bus_t bus;
  pmcg_ctl_t ctl;
  logic cpu_tick;
  int bad_count, checks, cnt;
  logic [7:0] exp_q[$];
  pmcg_ctrl pmcg_ctrl_inst (.clk_sys(clk_sys), .rst(rst), .bus(bus), .rdata(rdata),
    .int_enable(9'h1FF), .int_blocked(9'h000), .int_pin_n(pin_n), .int_is_pin(is_pin),
    .unclocked_wake(1'b0), .uart_rx_pin(rx_pin), .uart_rx_enable(rx_en),
    .uart_tx_load(tx_ld), .reset_pin_n(1'b1), .wdt_reset(wdt_rst),
    .slow_osc_tick(slow_tick), .src_stable(1'b1), .ctl(ctl), .cpu_tick(cpu_tick));
  pmcg_irq_model pmcg_irq_model_inst (.clk_sys(clk_sys), .rst(rst), .req(req), .clr(clr),
    .wake_pulse(ctl.wake_pulse), .int_pin_n(pin_n), .int_is_pin(is_pin));
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  // One-cycle strobes; a gap cycle follows each access
  task automatic acc(input logic [7:0] a, input logic [7:0] d, input logic w);
    @(posedge clk_sys);
    bus <= '{a, d, w, ~w};
    @(posedge clk_sys);
    bus <= '{a, 8'h00, 1'b0, 1'b0};
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    acc(a, 8'h00, 1'b0);
  endtask
  task automatic ticks(input int n);
    cnt = 0;
    repeat (n) begin
      @(posedge clk_sys);
      #1 cnt += int'(cpu_tick);
    end
  endtask
  task automatic wait_wake();
    for (int n = 0; n < 100 && ctl.wake_pulse !== 1'b1; n++) @(posedge clk_sys) #1;
    `CHK(ctl.wake_pulse, 1'b1)
  endtask
  // Read data stand only in the cycle after the strobe
  always @(posedge clk_sys) begin
    if (rd_q) begin
      exp_v = exp_q.pop_front();
      `CHK(rdata, exp_v)
    end
    rd_q <= bus.rd;
  end
  task automatic final_report();
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // Run needs about 3900 cycles; allow ten times that
  initial begin
    #1600000;
    bad_count++;
    final_report();
  end
  initial begin
    {rst, tx_ld, rx_pin, wdt_rst, clr, rd_q} = 6'b101000;
    req = 9'h000;
    rx_en = 1'b1;
    slow_tick = 1'b0;
    bus = '{8'h00, 8'h00, 1'b0, 1'b0};
    seed = 32'hCECFEA53;
    repeat (20) @(posedge clk_sys);
    rst <= 1'b0;
    rd(PMCG_DIVCTL_OFS, PMCG_DIVCTL_RST);
    rd(PMCG_WAKE_UP_MASK_OFS, PMCG_WAKE_UP_MASK_RST);
    rd(PMCG_CLOCK_SOURCE_FIELD_OFS, 8'h00);
    rd(8'h10, 8'h00);
    repeat (4) begin
      seed = xs(seed);
      acc(PMCG_WAKE_UP_MASK_OFS, seed[7:0], 1'b1);
      rd(PMCG_WAKE_UP_MASK_OFS, seed[7:0]);
    end
    acc(PMCG_WAKE_UP_MASK_OFS, 8'hFF, 1'b1);
    acc(PMCG_DIVCTL_OFS, 8'hC0, 1'b1);
    ticks(516);
    ticks(514);
    `CHK(cnt, 2)
    `CHK(ctl.ext_clk_en, 1'b1)
    acc(PMCG_DIVCTL_OFS, 8'h40, 1'b1);
    ticks(260);
    ticks(10);
    `CHK(cnt, 10)
    // Each switch-back source in turn: transmit load, start bit, interrupt, disabled receiver
    for (int k = 0; k < 4; k++) begin
      acc(PMCG_DIVCTL_OFS, 8'hE0, 1'b1);
      repeat (3) @(posedge clk_sys);
      tx_ld <= (k == 0);
      rx_pin <= !(k inside {1, 3});
      rx_en <= (k != 3);
      req <= {6'h00, k == 2, 2'b00};
      @(posedge clk_sys);
      {tx_ld, req} <= 10'h000;
      repeat (6) @(posedge clk_sys);
      rx_pin <= 1'b1;
      clr <= 1'b1;
      rd(PMCG_DIVCTL_OFS, (k == 3) ? 8'hE0 : 8'h60);
      clr <= 1'b0;
      repeat (600) @(posedge clk_sys);
      rd(PMCG_DIVCTL_OFS, (k == 3) ? 8'hE0 : 8'h60);
    end
    acc(PMCG_DIVCTL_OFS, 8'hC0, 1'b1);
    wdt_rst <= 1'b1;
    @(posedge clk_sys);
    wdt_rst <= 1'b0;
    repeat (3) @(posedge clk_sys);
    rd(PMCG_DIVCTL_OFS, 8'h40);
    acc(PMCG_POWER_CONTROL_REGISTER_OFS, 8'h01, 1'b1);
    repeat (3) @(posedge clk_sys);
    #1 `CHK({ctl.cpu_clk_en, ctl.ext_clk_en}, 2'b01)
    req <= 9'h040;
    @(posedge clk_sys);
    req <= 9'h000;
    wait_wake();
    repeat (2) @(posedge clk_sys);
    #1 `CHK(ctl.cpu_clk_en, 1'b1)
    acc(PMCG_CLOCK_SOURCE_FIELD_OFS, 8'h0E, 1'b1);
    repeat (3) @(posedge clk_sys);
    #1 `CHK(ctl.sel_slow, 1'b1)
    acc(PMCG_POWER_CONTROL_REGISTER_OFS, 8'h02, 1'b1);
    repeat (3) @(posedge clk_sys);
    #1 `CHK({ctl.internal_oscillator_en, ctl.cpu_clk_en, ctl.ext_clk_en}, 3'b000)
    req <= 9'h001;
    @(posedge clk_sys);
    req <= 9'h000;
    wait_wake();
    repeat (2) @(posedge clk_sys);
    #1 `CHK({ctl.internal_oscillator_en, ctl.sel_slow}, 2'b10)
    // Sleep with the shortest-but-one settle code and a slow tick every cycle
    acc(PMCG_CLOCK_SOURCE_FIELD_OFS, 8'h04, 1'b1);
    slow_tick <= 1'b1;
    acc(PMCG_POWER_CONTROL_REGISTER_OFS, 8'h12, 1'b1);
    repeat (3) @(posedge clk_sys);
    #1 `CHK({ctl.main_reg_en, ctl.internal_oscillator_en}, 2'b00)
    @(posedge clk_sys);
    req <= 9'h002;
    @(posedge clk_sys);
    req <= 9'h000;
    cnt = 0;
    while (ctl.wake_pulse !== 1'b1 && cnt < 300) begin
      @(posedge clk_sys);
      #1 cnt++;
    end
    // Two sync stages, stop exit and the resume cycle add four cycles to the settle count
    `CHK(cnt, (PMCG_SETTLE_BASE << 1) + 4)
    `CHK(ctl.main_reg_en, 1'b1)
    rd(PMCG_POWER_CONTROL_REGISTER_OFS, 8'h00);
    repeat (2) @(posedge clk_sys);
    final_report();
  end
endmodule // tb
